// >>> verif/testbench.sv
// Self-checking bench for the serial link register block.
// Assumes the checker is bound in and the transceiver model on pins 1 and 0.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import vpwl_pkg::*;
  localparam int DB = 9;
  localparam int DS = 1;
  logic CLK = 1'h0;
  logic RESET = 1'h1;
  logic [7:0] S_AXI_AWADDR = 8'h00;
  logic [7:0] S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0000_0000;
  logic S_AXI_AWVALID = 1'h0;
  logic S_AXI_WVALID = 1'h0;
  logic S_AXI_ARVALID = 1'h0;
  logic SPECIAL_MODE = 1'h0;
  logic TX_BUSY = 1'h0;
  logic LINK_TX = 1'h0;
  logic bus_dom = 1'h0;
  logic [9:0] evp = 10'h000;
  logic [7:0] RX_BYTE = 8'h00;
  logic [5:0] ext_hi = 6'h15;
  logic rx_pin;
  logic [6:0] PIN_IN, PIN_OUT, PIN_OE;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, TX_LOAD, TX_ABORT, END_OF_DATA, LINK_HOLD, LINK_ON;
  logic LOOP_DIGITAL, LOOP_ANALOG, LINK_RX, XCVR_ONCHIP;
  logic PIN_PULLUP, PIN_REDUCED;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0] S_AXI_RDATA;
  logic [7:0] TX_BYTE;
  logic [7:0] last_tx = 8'h00;
  logic [12:0] DELAY_CYCLES;
  logic [3:0] INT_CODE;
  int num_errors = 0;
  int n_checks = 0;
  int loads = 0;

  always #2 CLK = ~CLK;

  vpwl_link_port #(.DELAY_BASE_CYCLES(DB), .DELAY_STEP_CYCLES(DS))
  vpwl_link_port_inst (.CLK, .RESET, .S_AXI_AWADDR, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB(4'hF), .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY(1'h1),
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
    .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY(1'h1), .SPECIAL_MODE,
    .EV_EOF(evp[0]), .EV_RX_BYTE(evp[1]), .EV_RESP_BYTE(evp[2]), .RX_BYTE,
    .EV_ARB_LOSS(evp[3]), .EV_CRC_ERR(evp[4]), .EV_BAD_SYMBOL(evp[5]),
    .EV_WAKEUP(evp[6]), .TX_NEED_BYTE(evp[7]), .TX_FIRST_BIT(evp[8]),
    .TX_BUSY, .EOD_SENT(evp[9]), .LINK_TX, .TX_LOAD, .TX_BYTE, .TX_ABORT,
    .END_OF_DATA, .LINK_HOLD, .LOOP_DIGITAL, .LOOP_ANALOG, .LINK_RX,
    .LINK_ON, .XCVR_ONCHIP, .DELAY_CYCLES, .INT_CODE, .PIN_IN, .PIN_OUT,
    .PIN_OE, .PIN_PULLUP, .PIN_REDUCED);

  vpwl_xcvr_model vpwl_xcvr_model_inst (.tx_pin(PIN_OUT[PIN_TX]),
    .tx_oe(PIN_OE[PIN_TX]), .bus_dom, .rx_pin);
  // Wire level: whoever enables drives, else the outside world
  assign PIN_IN = (PIN_OE & PIN_OUT) | (~PIN_OE & {ext_hi, rx_pin});

  always @(posedge CLK) begin
    if (TX_LOAD === 1'h1) begin
      loads <= loads + 1;
      last_tx <= TX_BYTE;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [1:0] exp_resp(input logic [7:0] a);
    return (a > OFF_LCTL) ? RESP_SLVERR : RESP_OKAY;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w;
    aw = 1'h0;
    w = 1'h0;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h00_0000, d};
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    while (!(aw && w)) begin
      @(posedge CLK);
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw = 1'h1;
        S_AXI_AWVALID <= 1'h0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w = 1'h1;
        S_AXI_WVALID <= 1'h0;
      end
    end
    do @(posedge CLK); while (S_AXI_BVALID !== 1'h1);
    chk("write resp", 32'(exp_resp(a)), 32'(S_AXI_BRESP));
    // Lets registered outputs settle before the caller looks
    @(posedge CLK);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'h1;
    do @(posedge CLK); while (S_AXI_ARREADY !== 1'h1);
    S_AXI_ARVALID <= 1'h0;
    do @(posedge CLK); while (S_AXI_RVALID !== 1'h1);
    chk($sformatf("read %h", a), {24'h00_0000, e}, S_AXI_RDATA);
    chk("read resp", 32'(exp_resp(a)), 32'(S_AXI_RRESP));
  endtask

  task automatic pulse(input logic [9:0] m);
    @(posedge CLK);
    evp <= m;
    @(posedge CLK);
    evp <= 10'h000;
    repeat (3) @(posedge CLK);
  endtask

  task automatic t_reset;
    rd(OFF_VECTOR, 8'h00);
    rd(OFF_RTD, RTD_RESET);
    rd(OFF_PCTL, PCTL_RESET);
    rd(OFF_PDAT, {1'h0, ext_hi, 1'h1});
    rd(OFF_PDIR, {1'h0, PDIR_RESET});
    chk("pin enables", 32'h0, 32'(PIN_OE));
    rd(8'h1C, 8'h00);
    wr(8'h1C, 8'hFF);
  endtask

  task automatic t_prio;
    logic [3:0] s [5];
    s = '{SRC_WAKEUP, SRC_CRC_ERR, SRC_ARB_LOSS, SRC_EOF, SRC_NONE};
    pulse(10'h059);
    chk("int code", 32'(SRC_WAKEUP), 32'(INT_CODE));
    foreach (s[i]) rd(OFF_VECTOR, {2'h0, s[i], 2'h0});
  endtask

  task automatic t_rx(input logic [9:0] m, input logic [3:0] c,
    input logic [7:0] b);
    RX_BYTE <= b;
    pulse(m);
    rd(OFF_VECTOR, {2'h0, c, 2'h0});
    rd(OFF_VECTOR, {2'h0, c, 2'h0});
    rd(OFF_DATA, b);
    rd(OFF_VECTOR, 8'h00);
  endtask

  task automatic t_tx;
    TX_BUSY <= 1'h1;
    wr(OFF_DATA, 8'h3C);
    pulse(10'h080);
    chk("loaded byte", 32'h3C, 32'(last_tx));
    pulse(10'h100);
    rd(OFF_VECTOR, 8'h10);
    wr(OFF_DATA, 8'h77);
    rd(OFF_VECTOR, 8'h00);
    pulse(10'h080);
    chk("loads", 32'h2, 32'(loads));
    pulse(10'h100);
    pulse(10'h080);
    chk("abort", 32'h1, 32'(TX_ABORT));
    rd(OFF_LCTL, 8'h80);
    rd(OFF_VECTOR, 8'h1C);
    // Hold shows three registers after the clearing read
    repeat (2) @(posedge CLK);
    chk("hold", 32'h1, 32'(LINK_HOLD));
    rd(OFF_VECTOR, 8'h10);
    wr(OFF_LCTL, 8'h81);
    rd(OFF_VECTOR, 8'h00);
    chk("end of data", 32'h1, 32'(END_OF_DATA));
    TX_BUSY <= 1'h0;
    pulse(10'h200);
    chk("end of data", 32'h0, 32'(END_OF_DATA));
    chk("abort end", 32'h0, 32'(TX_ABORT));
    rd(OFF_LCTL, 8'h00);
  endtask

  task automatic t_hold;
    wr(OFF_DATA, 8'h11);
    pulse(10'h082);
    rd(OFF_VECTOR, 8'h00);
    chk("loads", 32'h2, 32'(loads));
    pulse(10'h001);
    chk("hold", 32'h0, 32'(LINK_HOLD));
    rd(OFF_VECTOR, 8'h04);
    rd(OFF_VECTOR, 8'h00);
  endtask

  task automatic t_loop(input logic [7:0] v);
    wr(OFF_LCTL, v);
    chk("loop", 32'(v[2:1]), 32'({LOOP_ANALOG, LOOP_DIGITAL}));
    pulse(10'h053);
    rd(OFF_VECTOR, 8'h00);
    wr(OFF_LCTL, 8'h00);
  endtask

  task automatic t_rtd;
    wr(OFF_RTD, 8'h4F);
    rd(OFF_RTD, 8'h4F);
    chk("delay", 32'(DB + 15 * DS), 32'(DELAY_CYCLES));
    wr(OFF_RTD, 8'h40);
    rd(OFF_RTD, 8'h4F);
    SPECIAL_MODE <= 1'h1;
    wr(OFF_RTD, 8'h80);
    chk("onchip", 32'h1, 32'(XCVR_ONCHIP));
    wr(OFF_RTD, 8'h00);
    chk("delay", 32'(DB), 32'(DELAY_CYCLES));
  endtask

  task automatic t_port;
    wr(OFF_PDIR, 8'h7F);
    wr(OFF_PDAT, 8'h55);
    chk("pin enables", 32'h7F, 32'(PIN_OE));
    chk("pins", 32'h55, 32'(PIN_OUT));
    rd(OFF_PDAT, 8'h55);
    wr(OFF_PDIR, 8'h0F);
    rd(OFF_PDAT, 8'h25);
    wr(OFF_PCTL, 8'h07);
    chk("drive", 32'h3, 32'({PIN_PULLUP, PIN_REDUCED}));
    chk("link on", 32'h1, 32'(LINK_ON));
    LINK_TX <= 1'h1;
    wr(OFF_PDAT, 8'h00);
    chk("tx pin", 32'h1, 32'(PIN_OUT[PIN_TX]));
    chk("rx inverted", 32'h1, 32'(LINK_RX));
    LINK_TX <= 1'h0;
    bus_dom <= 1'h1;
    wr(OFF_RTD, 8'h40);
    chk("rx true", 32'h0, 32'(LINK_RX));
    wr(OFF_PCTL, 8'h00);
    chk("rx off", 32'h1, 32'(LINK_RX));
    chk("pin enables", 32'h0F, 32'(PIN_OE));
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge CLK);
    num_errors++;
    wrap_up();
  end

  initial begin
    repeat (12) @(posedge CLK);
    RESET <= 1'h0;
    repeat (2) @(posedge CLK);
    t_reset();
    t_prio();
    RX_BYTE <= 8'h11;
    pulse(10'h002);
    t_rx(10'h002, SRC_RX_FULL, 8'hA5);
    t_rx(10'h004, SRC_RESP_BYTE, 8'h5A);
    t_tx();
    t_hold();
    t_loop(8'h02);
    t_loop(8'h04);
    t_rtd();
    t_port();
    wrap_up();
  end
endmodule
`default_nettype wire

// >>> verif/vpwl_link_port_props.sv
// Checker on the serial link block ports.
// Assumes one clock and frame events as one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module vpwl_link_port_props
  import vpwl_pkg::*;
#(
  parameter int unsigned DELAY_BASE_CYCLES = DELAY_BASE_CYC,
  parameter int unsigned DELAY_STEP_CYCLES = DELAY_STEP_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Bus and engine side
  input wire logic S_AXI_RVALID,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic EV_WAKEUP,
  input wire logic TX_NEED_BYTE,
  input wire logic TX_BUSY,
  // Design outputs
  input wire logic TX_LOAD,
  input wire logic TX_ABORT,
  input wire logic END_OF_DATA,
  input wire logic LINK_HOLD,
  input wire logic LOOP_DIGITAL,
  input wire logic LOOP_ANALOG,
  input wire logic LINK_ON,
  input wire logic [3:0] INT_CODE,
  input wire logic [6:0] PIN_OE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  logic lp;
  assign lp = LOOP_DIGITAL || LOOP_ANALOG;

  chk_rdata_upper:
    assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  chk_load_once:
    assert property (TX_LOAD |=> !TX_LOAD) else $error("load not a pulse");
  chk_load_cause:
    assert property ($rose(TX_LOAD) |-> $past(TX_NEED_BYTE && !LINK_HOLD))
    else $error("load without request");
  chk_abort_stays:
    assert property (TX_ABORT && TX_BUSY |=> TX_ABORT)
    else $error("abort dropped while busy");
  chk_abort_cause:
    assert property ($rose(TX_ABORT) |->
      $past(TX_NEED_BYTE && TX_BUSY && !END_OF_DATA))
    else $error("abort without underrun");
  chk_loop_gate:
    assert property (lp && $past(lp) && EV_WAKEUP &&
      INT_CODE != SRC_WAKEUP |-> ##3 INT_CODE != SRC_WAKEUP)
    else $error("bus event seen in loopback");
  chk_wake_shown:
    assert property (EV_WAKEUP && !lp |-> ##3 INT_CODE == SRC_WAKEUP)
    else $error("wakeup not on top");
  chk_link_pins:
    assert property (LINK_ON && $past(LINK_ON) |-> PIN_OE[1:0] == 2'h2)
    else $error("link pins wrong direction");

  cov_load: cover property (TX_LOAD);
  cov_abort: cover property ($rose(TX_ABORT));
  cov_hold: cover property ($fell(LINK_HOLD));
endmodule
bind vpwl_link_port vpwl_link_port_props #(
  .DELAY_BASE_CYCLES(DELAY_BASE_CYCLES),
  .DELAY_STEP_CYCLES(DELAY_STEP_CYCLES)
) vpwl_link_port_props_inst (.CLK, .RESET, .S_AXI_RVALID, .S_AXI_RDATA,
  .EV_WAKEUP, .TX_NEED_BYTE, .TX_BUSY, .TX_LOAD, .TX_ABORT, .END_OF_DATA,
  .LINK_HOLD, .LOOP_DIGITAL, .LOOP_ANALOG, .LINK_ON, .INT_CODE, .PIN_OE);
`default_nettype wire

// >>> verif/vpwl_xcvr_model.sv
// Model of the off-chip bus transceiver on the link pins.
// Assumes pin 1 carries transmit and pin 0 receive.
`timescale 1ns/1ps
`default_nettype none
module vpwl_xcvr_model #(
  parameter bit INVERT = 1'h1
) (
  // Device side
  input wire logic tx_pin,
  input wire logic tx_oe,
  // Far nodes
  input wire logic bus_dom,
  output logic rx_pin
);
  logic bus_lvl;
  // Wired bus: any node may assert the dominant level
  assign bus_lvl = bus_dom | (tx_oe & tx_pin);
  // Many parts hand the bus back inverted
  assign rx_pin = INVERT ? ~bus_lvl : bus_lvl;
endmodule
`default_nettype wire

// >>> verilog/vpwl_link_port.sv
// Register block of the serial link controller: AXI4-Lite slave, state
// vector access, double-buffered data register, delay config, shared port.
// Assumes a frame engine beside it supplying one-cycle event pulses.
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module vpwl_link_port
  import vpwl_pkg::*;
#(
  parameter int unsigned DELAY_BASE_CYCLES = DELAY_BASE_CYC,
  parameter int unsigned DELAY_STEP_CYCLES = DELAY_STEP_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // AXI4-Lite write
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Chip mode
  input wire logic SPECIAL_MODE,
  // Frame engine events
  input wire logic EV_EOF,
  input wire logic EV_RX_BYTE,
  input wire logic EV_RESP_BYTE,
  input wire logic [7:0] RX_BYTE,
  input wire logic EV_ARB_LOSS,
  input wire logic EV_CRC_ERR,
  input wire logic EV_BAD_SYMBOL,
  input wire logic EV_WAKEUP,
  // Frame engine transmit handshake
  input wire logic TX_NEED_BYTE,
  input wire logic TX_FIRST_BIT,
  input wire logic TX_BUSY,
  input wire logic EOD_SENT,
  input wire logic LINK_TX,
  output logic TX_LOAD,
  output logic [7:0] TX_BYTE,
  output logic TX_ABORT,
  output logic END_OF_DATA,
  output logic LINK_HOLD,
  output logic LOOP_DIGITAL,
  output logic LOOP_ANALOG,
  output logic LINK_RX,
  output logic LINK_ON,
  // Transceiver settings
  output logic XCVR_ONCHIP,
  output logic [12:0] DELAY_CYCLES,
  // Pending source
  output logic [3:0] INT_CODE,
  // Shared port pins
  input wire logic [6:0] PIN_IN,
  output logic [6:0] PIN_OUT,
  output logic [6:0] PIN_OE,
  output logic PIN_PULLUP,
  output logic PIN_REDUCED
);
  vpwl_vec_if vif ();

  logic aw_got_r;
  logic [7:0] awaddr_r;
  logic w_got_r;
  logic [7:0] wdata_r;
  logic wlane_r;
  logic do_wr;
  logic wr_en;
  logic do_rd;
  logic [7:0] rd_val;
  logic [7:0] rtd_r;
  logic rtd_locked_r;
  logic [7:0] pctl_r;
  logic [6:0] pdat_r;
  logic [6:0] pdir_r;
  logic eod_r;
  logic digital_loopback_r;
  logic analog_loopback_r;
  logic underrun_r;
  logic lock_r;
  logic [7:0] rx_shadow_r;
  logic [7:0] tx_shadow_r;
  logic tx_full_r;
  logic detached;
  logic bus_ok;
  logic load_now;
  logic underrun_evt;
  logic link_en;

  assign link_en = pctl_r[PCTL_LINK_EN_BIT];
  assign detached = digital_loopback_r | analog_loopback_r;
  assign bus_ok = ~detached & ~lock_r;
  assign do_wr = aw_got_r & w_got_r & ~S_AXI_BVALID;
  assign wr_en = do_wr & wlane_r;
  assign do_rd = S_AXI_ARVALID & S_AXI_ARREADY;
  assign load_now = TX_NEED_BYTE & tx_full_r & ~lock_r;
  assign underrun_evt = TX_NEED_BYTE & TX_BUSY & ~tx_full_r & ~eod_r &
    ~TX_ABORT & ~lock_r;

  // Write address and data are taken in either order
  always_ff @(posedge CLK) begin
    if (RESET) begin
      aw_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      S_AXI_AWREADY <= 1'b0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_got_r <= 1'b1;
      awaddr_r <= S_AXI_AWADDR;
      S_AXI_AWREADY <= 1'b0;
    end else if (do_wr) begin
      aw_got_r <= 1'b0;
    end else if (!aw_got_r && !S_AXI_BVALID) begin
      S_AXI_AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      w_got_r <= 1'b0;
      wdata_r <= 8'h00;
      wlane_r <= 1'b0;
      S_AXI_WREADY <= 1'b0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_got_r <= 1'b1;
      wdata_r <= S_AXI_WDATA[7:0];
      wlane_r <= S_AXI_WSTRB[0];
      S_AXI_WREADY <= 1'b0;
    end else if (do_wr) begin
      w_got_r <= 1'b0;
    end else if (!w_got_r && !S_AXI_BVALID) begin
      S_AXI_WREADY <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else if (do_wr) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= reg_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Read mux; the vector value is the code shifted up by two
  always_comb begin
    unique case (S_AXI_ARADDR)
      OFF_VECTOR: rd_val = {2'b00, vif.code, 2'b00};
      OFF_DATA: rd_val = rx_shadow_r;
      OFF_RTD: rd_val = rtd_r;
      OFF_PCTL: rd_val = pctl_r;
      OFF_PDAT: rd_val = {1'b0, (pdir_r & pdat_r) | (~pdir_r & PIN_IN)};
      OFF_PDIR: rd_val = {1'b0, pdir_r};
      OFF_LCTL: rd_val = {underrun_r, 4'h0, analog_loopback_r, digital_loopback_r, eod_r};
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (do_rd) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= {24'h00_0000, rd_val};
      S_AXI_RRESP <= reg_mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RVALID) begin
      if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end else begin
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // Access strobes and bus events towards the state vector
  assign vif.vec_rd = do_rd && S_AXI_ARADDR == OFF_VECTOR;
  assign vif.data_rd = do_rd && S_AXI_ARADDR == OFF_DATA;
  assign vif.data_wr = wr_en && awaddr_r == OFF_DATA;
  assign vif.eod_req = wr_en && awaddr_r == OFF_LCTL &&
    wdata_r[LCTL_EOD_BIT];
  always_comb begin
    vif.set = '0;
    vif.set[SRC_EOF] = EV_EOF & ~detached;
    vif.set[SRC_RESP_BYTE] = EV_RESP_BYTE & bus_ok;
    vif.set[SRC_RX_FULL] = EV_RX_BYTE & bus_ok;
    vif.set[SRC_TX_EMPTY] = TX_FIRST_BIT & ~lock_r;
    vif.set[SRC_ARB_LOSS] = EV_ARB_LOSS & bus_ok;
    vif.set[SRC_CRC_ERR] = EV_CRC_ERR & bus_ok;
    vif.set[SRC_BAD_SYMBOL] = (EV_BAD_SYMBOL & bus_ok) |
      underrun_evt;
    vif.set[SRC_WAKEUP] = EV_WAKEUP & ~detached;
  end

  vpwl_vector u_vector (
    .clk(CLK),
    .rst(RESET),
    .v(vif)
  );

  always_ff @(posedge CLK) begin
    if (RESET) begin
      INT_CODE <= SRC_NONE;
    end else begin
      INT_CODE <= vif.code;
    end
  end

  // Traffic stays held from an invalid-symbol clear to the next frame end
  always_ff @(posedge CLK) begin
    if (RESET) begin
      lock_r <= 1'b0;
    end else if (vif.bad_cleared) begin
      lock_r <= 1'b1;
    end else if (EV_EOF && !detached) begin
      lock_r <= 1'b0;
    end
  end

  // Receive shadow is overwritten by the next byte if not read in time
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rx_shadow_r <= 8'h00;
    end else if ((EV_RX_BYTE || EV_RESP_BYTE) && bus_ok) begin
      rx_shadow_r <= RX_BYTE;
    end
  end

  // Transmit shadow; a write in the load cycle keeps the buffer full
  always_ff @(posedge CLK) begin
    if (RESET) begin
      tx_shadow_r <= 8'h00;
      tx_full_r <= 1'b0;
    end else if (vif.data_wr) begin
      tx_shadow_r <= wdata_r;
      tx_full_r <= 1'b1;
    end else if (load_now) begin
      tx_full_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      TX_LOAD <= 1'b0;
      TX_BYTE <= 8'h00;
    end else begin
      TX_LOAD <= load_now;
      if (load_now) begin
        TX_BYTE <= tx_shadow_r;
      end
    end
  end

  // Abort stands until the engine has sent its two ones and gone idle
  always_ff @(posedge CLK) begin
    if (RESET) begin
      TX_ABORT <= 1'b0;
    end else if (underrun_evt) begin
      TX_ABORT <= 1'b1;
    end else if (!TX_BUSY) begin
      TX_ABORT <= 1'b0;
    end
  end

  // Link control: end-of-data, loopback, sticky underrun status
  always_ff @(posedge CLK) begin
    if (RESET) begin
      eod_r <= 1'b0;
      digital_loopback_r <= 1'b0;
      analog_loopback_r <= 1'b0;
    end else if (wr_en && awaddr_r == OFF_LCTL) begin
      // A request written as the engine reports sent still stands
      eod_r <= wdata_r[LCTL_EOD_BIT] | (eod_r & ~EOD_SENT);
      digital_loopback_r <= wdata_r[LCTL_DIGITAL_LOOPBACK_BIT];
      analog_loopback_r <= wdata_r[LCTL_ANALOG_LOOPBACK_BIT];
    end else if (EOD_SENT) begin
      eod_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      underrun_r <= 1'b0;
    end else if (underrun_evt) begin
      underrun_r <= 1'b1;
    end else if (wr_en && awaddr_r == OFF_LCTL &&
        wdata_r[LCTL_UNDERRUN_BIT]) begin
      underrun_r <= 1'b0;
    end
  end

  // Delay config locks after its first write; writes in special mode pass the lock
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rtd_r <= RTD_RESET;
      rtd_locked_r <= 1'b0;
    end else if (wr_en && awaddr_r == OFF_RTD &&
        (SPECIAL_MODE || !rtd_locked_r)) begin
      rtd_r <= wdata_r;
      rtd_locked_r <= 1'b1;
    end
  end

  // Port registers
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pctl_r <= PCTL_RESET;
      pdat_r <= PDAT_RESET;
      pdir_r <= PDIR_RESET;
    end else if (wr_en) begin
      if (awaddr_r == OFF_PCTL) begin
        pctl_r <= {5'h00, wdata_r[2:0]};
      end
      if (awaddr_r == OFF_PDAT) begin
        pdat_r <= wdata_r[6:0];
      end
      if (awaddr_r == OFF_PDIR) begin
        pdir_r <= wdata_r[6:0];
      end
    end
  end

  // Pin drive; the link owns its receive and transmit pins when enabled
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PIN_OUT <= 7'h00;
      PIN_OE <= 7'h00;
    end else begin
      PIN_OUT <= pdat_r;
      PIN_OE <= pdir_r;
      if (link_en) begin
        PIN_OUT[PIN_TX] <= LINK_TX;
        PIN_OE[PIN_TX] <= 1'b1;
        PIN_OE[PIN_RX] <= 1'b0;
      end
    end
  end

  // Settings outputs, all from flops
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PIN_PULLUP <= 1'b0;
      PIN_REDUCED <= 1'b0;
      LINK_ON <= 1'b0;
      LINK_RX <= 1'b1;
      XCVR_ONCHIP <= 1'b0;
      DELAY_CYCLES <= 13'h0000;
      LOOP_DIGITAL <= 1'b0;
      LOOP_ANALOG <= 1'b0;
      LINK_HOLD <= 1'b0;
      END_OF_DATA <= 1'b0;
    end else begin
      PIN_PULLUP <= pctl_r[PCTL_PULLUP_BIT];
      PIN_REDUCED <= pctl_r[PCTL_REDUCED_BIT];
      LINK_ON <= link_en;
      // Idle-high receive level while the port is not the link's
      LINK_RX <= link_en ? (rtd_r[RTD_POL_BIT] ? PIN_IN[PIN_RX] :
        ~PIN_IN[PIN_RX]) : 1'b1;
      XCVR_ONCHIP <= rtd_r[RTD_XCVR_BIT];
      DELAY_CYCLES <= 13'(DELAY_BASE_CYCLES + 32'(rtd_r[3:0]) *
        DELAY_STEP_CYCLES);
      LOOP_DIGITAL <= digital_loopback_r;
      LOOP_ANALOG <= analog_loopback_r;
      LINK_HOLD <= lock_r;
      END_OF_DATA <= eod_r;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/vpwl_pkg.sv
// Constants shared by the serial link register block and its vector logic.
// Assumes a 250 MHz module clock and an 8-bit AXI4-Lite byte address.
package vpwl_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_VECTOR = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_RTD = 8'h08;
  localparam logic [7:0] OFF_PCTL = 8'h0C;
  localparam logic [7:0] OFF_PDAT = 8'h10;
  localparam logic [7:0] OFF_PDIR = 8'h14;
  localparam logic [7:0] OFF_LCTL = 8'h18;

  // Interrupt source codes, lowest to highest priority
  localparam logic [3:0] SRC_NONE = 4'h0;
  localparam logic [3:0] SRC_EOF = 4'h1;
  localparam logic [3:0] SRC_RESP_BYTE = 4'h2;
  localparam logic [3:0] SRC_RX_FULL = 4'h3;
  localparam logic [3:0] SRC_TX_EMPTY = 4'h4;
  localparam logic [3:0] SRC_ARB_LOSS = 4'h5;
  localparam logic [3:0] SRC_CRC_ERR = 4'h6;
  localparam logic [3:0] SRC_BAD_SYMBOL = 4'h7;
  localparam logic [3:0] SRC_WAKEUP = 4'h8;
  localparam int NUM_SRC = 9;

  // Field positions
  localparam int VEC_CODE_LSB = 2;
  localparam int RTD_OFFSET_LSB = 0;
  localparam int RTD_POL_BIT = 6;
  localparam int RTD_XCVR_BIT = 7;
  localparam int PCTL_REDUCED_BIT = 0;
  localparam int PCTL_PULLUP_BIT = 1;
  localparam int PCTL_LINK_EN_BIT = 2;
  localparam int LCTL_EOD_BIT = 0;
  localparam int LCTL_DIGITAL_LOOPBACK_BIT = 1;
  localparam int LCTL_ANALOG_LOOPBACK_BIT = 2;
  localparam int LCTL_UNDERRUN_BIT = 7;
  localparam int PIN_RX = 0;
  localparam int PIN_TX = 1;
  localparam int NUM_PINS = 7;

  // Reset values
  localparam logic [7:0] RTD_RESET = 8'h00;
  localparam logic [7:0] PCTL_RESET = 8'h00;
  localparam logic [6:0] PDAT_RESET = 7'h00;
  localparam logic [6:0] PDIR_RESET = 7'h00;

  // Round-trip delay compensation timing
  localparam int DELAY_BASE_US = 9;
  localparam int DELAY_STEP_US = 1;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PS_PER_US = 1000000;
  localparam int CYC_PER_US = PS_PER_US / CLK_PERIOD_PS;
  localparam int DELAY_BASE_CYC = DELAY_BASE_US * CYC_PER_US;
  localparam int DELAY_STEP_CYC = DELAY_STEP_US * CYC_PER_US;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // True when the byte address hits a register word
  function automatic logic reg_mapped(input logic [7:0] addr);
    reg_mapped = (addr == OFF_VECTOR) || (addr == OFF_DATA) ||
      (addr == OFF_RTD) || (addr == OFF_PCTL) || (addr == OFF_PDAT) ||
      (addr == OFF_PDIR) || (addr == OFF_LCTL);
  endfunction
endpackage

// >>> verilog/vpwl_vec_if.sv
// Carries event sets, access strobes and the pending code between the
// register block and the interrupt state vector logic. Same clock both ends.
`timescale 1ns/1ps
`default_nettype none
interface vpwl_vec_if;
  logic [8:0] set;
  logic vec_rd;
  logic data_rd;
  logic data_wr;
  logic eod_req;
  logic [3:0] code;
  logic bad_cleared;

  modport core (output set, output vec_rd, output data_rd, output data_wr,
    output eod_req, input code, input bad_cleared);
  modport vec (input set, input vec_rd, input data_rd, input data_wr,
    input eod_req, output code, output bad_cleared);
endinterface
`default_nettype wire

// >>> verilog/vpwl_vector.sv
// Interrupt state vector: sticky sources, priority pick and clear rules.
// Assumes one-cycle strobes from the register block on the same clock.
`timescale 1ns/1ps
`default_nettype none
module vpwl_vector
  import vpwl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Block side
  vpwl_vec_if.vec v
);
  logic [8:0] flags_r;
  logic [8:0] clr;
  logic [3:0] code_r;
  logic [3:0] code_nxt;
  logic rx_arm_r;
  logic [3:0] rx_arm_code_r;
  logic tx_arm_r;
  logic bad_clr_r;

  // Highest set flag wins, wakeup on top
  always_comb begin
    code_nxt = SRC_NONE;
    for (int i = 1; i < NUM_SRC; i++) begin
      if (flags_r[i]) begin
        code_nxt = 4'(i);
      end
    end
  end

  always_comb begin
    clr = '0;
    if (v.vec_rd && code_r != SRC_NONE && code_r != SRC_RESP_BYTE &&
        code_r != SRC_RX_FULL && code_r != SRC_TX_EMPTY) begin
      clr[code_r] = 1'b1;
    end
    if (v.data_rd && rx_arm_r) begin
      clr[rx_arm_code_r] = 1'b1;
    end
    if ((v.data_wr && tx_arm_r) || v.eod_req) begin
      clr[SRC_TX_EMPTY] = 1'b1;
    end
    clr[SRC_NONE] = 1'b0;
  end

  // A set in the same cycle as its clear is kept
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_r <= '0;
    end else begin
      flags_r <= (flags_r & ~clr) | (v.set & 9'h1_FE);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      code_r <= SRC_NONE;
    end else begin
      code_r <= code_nxt;
    end
  end

  // Data-register clears need a vector read showing that source first
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_arm_r <= 1'b0;
      rx_arm_code_r <= SRC_NONE;
      tx_arm_r <= 1'b0;
    end else begin
      if (v.vec_rd) begin
        rx_arm_r <= (code_r == SRC_RESP_BYTE) || (code_r == SRC_RX_FULL);
        rx_arm_code_r <= code_r;
        tx_arm_r <= (code_r == SRC_TX_EMPTY);
      end else begin
        if (v.data_rd) begin
          rx_arm_r <= 1'b0;
        end
        if (v.data_wr || v.eod_req) begin
          tx_arm_r <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bad_clr_r <= 1'b0;
    end else begin
      bad_clr_r <= clr[SRC_BAD_SYMBOL] & ~v.set[SRC_BAD_SYMBOL];
    end
  end

  assign v.code = code_r;
  assign v.bad_cleared = bad_clr_r;
endmodule
`default_nettype wire
